// ==== hdl/pmwu_consts.vh ====
// constants for the power mode and write unlock block
`ifndef PMWU_CONSTS_VH
`define PMWU_CONSTS_VH
`define PMWU_ADDR_POWER_CONTROL   8'h87
`define PMWU_ADDR_EXT_FLAG        8'h91
`define PMWU_ADDR_UNLOCK_KEY      8'hC7
`define PMWU_ADDR_WATCHDOG_CTRL   8'hD8
`define PMWU_BIT_IDLE             0
`define PMWU_BIT_STOP             1
`define PMWU_BIT_BANDGAP          0
`define PMWU_BIT_RING_SEL         1
`define PMWU_BIT_RING_ACT         2
`define PMWU_BIT_WD_RESTART       0
`define PMWU_BIT_WD_ENABLE        1
`define PMWU_BIT_WD_IRQ           3
`define PMWU_BIT_POR              6
`define PMWU_KEY_FIRST            8'hAA
`define PMWU_KEY_SECOND           8'h55
`define PMWU_UNLOCK_CYCLES        2
`define PMWU_XTAL_SWITCH_CLOCKS   65536
`define PMWU_POWER_CONTROL_RESET           8'h00
`define PMWU_EXTENDED_FLAG_CLOCK_SELECT_RESET           8'h00
`define PMWU_WATCHDOG_CONTROL_RESET          8'h40
`endif

// ==== hdl/pmwu_top.v ====
// power mode control, ring wake clock select and timed write unlock
// Operation
// - idle bit 0 of power control enters idle
// - idle halts cpu, keeps peripheral clocks
// - any enabled interrupt or reset ends idle
// - stop bit 1 gates all internal clocks
// - only external interrupt, power fail with bandgap, or reset ends stop
// - timer, serial, watchdog cannot wake stop
// - bandgap in stop makes power fail wake
// - bandgap in stop is bit 0, resets zero
// - bandgap bit ignored outside stop
// - stop disables crystal, restarts on exit
// - ring select wakes stop on ring clock
// - switch to crystal after 65536 clocks
// - stop again before switch kills ring
// - ring active flag set while ring clocks
// - AAh then 55h opens three cycle window
// - protected write ignored without unlock
// - protected bits list of five
//
// The APB slave port was left to the implementer.
`include "pmwu_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module pmwu_top #(
  parameter integer XTAL_SWITCH_CLOCKS = `PMWU_XTAL_SWITCH_CLOCKS
) (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // wake sources
  input  wire        irq_enabled,
  input  wire        ext_irq,
  input  wire        power_fail_interrupt,
  input  wire        power_fail_reset,
  // clock and power controls
  output wire        cpu_halt,
  output wire        periph_clk_en,
  output wire        xtal_osc_en,
  output wire        ring_osc_en,
  output wire        clk_sel_ring,
  output wire        bandgap_en,
  // watchdog control bits
  output wire        watchdog_enable_bit,
  output wire        watchdog_restart_bit,
  input  wire        watchdog_irq_set,
  output wire        watchdog_irq_flag
);
  localparam [3:0] ST_RUN  = 4'b0001;
  localparam [3:0] ST_IDLE = 4'b0010;
  localparam [3:0] ST_STOP = 4'b0100;
  localparam [3:0] ST_RING = 4'b1000;
  localparam [31:0] UL_CYC_W = `PMWU_UNLOCK_CYCLES;
  localparam [1:0]  UL_CYC   = UL_CYC_W[1:0];
  localparam [31:0] SW_MAX_W = XTAL_SWITCH_CLOCKS - 1;
  localparam [16:0] SW_MAX   = SW_MAX_W[16:0];

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [7:0]  power_control_q;
  reg         bgs_q;
  reg         ring_wake_select_q;
  reg         por_q;
  reg         ewt_q;
  reg         rwt_q;
  reg         watchdog_irq_flag_q;
  reg         key1_q;
  reg  [1:0]  win_q;
  reg  [16:0] sw_cnt_q;
  reg         ext_s1_q;
  reg         ext_s2_q;
  reg         pfi_s1_q;
  reg         pfi_s2_q;
  reg         pfr_s1_q;
  reg         pfr_s2_q;
  reg         irq_s1_q;
  reg         irq_s2_q;

  wire       wr    = psel & penable & pwrite & clk_en;
  wire [7:0] addr8 = paddr[9:2];
  wire       wr_lo = wr & pstrb[0];
  wire       prot_hit;
  wire       win_open = (win_q != 2'b00);
  wire       prot_ok  = win_open;
  wire       stop_wake;

  function hit;
    input [7:0] a;
    input [7:0] r;
    begin
      hit = (a == r) && (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hit(addr8, `PMWU_ADDR_POWER_CONTROL) |
                   hit(addr8, `PMWU_ADDR_EXT_FLAG) | hit(addr8, `PMWU_ADDR_UNLOCK_KEY) |
                   hit(addr8, `PMWU_ADDR_WATCHDOG_CTRL));
  assign prot_hit = wr_lo & (hit(addr8, `PMWU_ADDR_EXT_FLAG) |
                    hit(addr8, `PMWU_ADDR_WATCHDOG_CTRL));

  // stop wake: external always, power fail only with bandgap kept on
  assign stop_wake = ext_s2_q | (bgs_q & (pfi_s2_q | pfr_s2_q));

  // input synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      pfi_s1_q <= 1'b0;
      pfi_s2_q <= 1'b0;
      pfr_s1_q <= 1'b0;
      pfr_s2_q <= 1'b0;
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else if (clk_en) begin
      ext_s1_q <= ext_irq;
      ext_s2_q <= ext_s1_q;
      pfi_s1_q <= power_fail_interrupt;
      pfi_s2_q <= pfi_s1_q;
      pfr_s1_q <= power_fail_reset;
      pfr_s2_q <= pfr_s1_q;
      irq_s1_q <= irq_enabled;
      irq_s2_q <= irq_s1_q;
    end
  end

  // power state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (power_control_q[`PMWU_BIT_STOP])
          state_d = ST_STOP;
        else if (power_control_q[`PMWU_BIT_IDLE])
          state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (irq_s2_q)
          state_d = ST_RUN;
      end
      ST_STOP: begin
        if (stop_wake)
          state_d = ring_wake_select_q ? ST_RING : ST_RUN;
      end
      ST_RING: begin
        if (power_control_q[`PMWU_BIT_STOP])
          state_d = ST_STOP;
        else if (sw_cnt_q == SW_MAX)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_RUN;
      sw_cnt_q <= 17'h00000;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_q == ST_RING)
        sw_cnt_q <= sw_cnt_q + 17'h00001;
      else
        sw_cnt_q <= 17'h00000;
    end
  end

  // clock and power outputs
  assign cpu_halt      = (state_q != ST_RUN) & (state_q != ST_RING);
  assign periph_clk_en = (state_q != ST_STOP);
  assign xtal_osc_en   = (state_q != ST_STOP);
  assign ring_osc_en   = (state_q == ST_RING);
  assign clk_sel_ring  = (state_q == ST_RING);
  assign bandgap_en    = (state_q != ST_STOP) | bgs_q;
  assign watchdog_enable_bit  = ewt_q;
  assign watchdog_restart_bit = rwt_q;
  assign watchdog_irq_flag    = watchdog_irq_flag_q;

  // registers and timed access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_q <= `PMWU_POWER_CONTROL_RESET;
      bgs_q  <= 1'b0;
      ring_wake_select_q <= 1'b0;
      por_q  <= 1'b1;
      ewt_q  <= 1'b0;
      rwt_q  <= 1'b0;
      watchdog_irq_flag_q <= 1'b0;
      key1_q <= 1'b0;
      win_q  <= 2'b00;
    end else if (clk_en) begin
      rwt_q <= 1'b0;
      if (win_open)
        win_q <= win_q - 2'b01;
      if (wr_lo && hit(addr8, `PMWU_ADDR_UNLOCK_KEY)) begin
        if (key1_q && pwdata[7:0] == `PMWU_KEY_SECOND) begin
          win_q  <= UL_CYC + 2'b01;
          key1_q <= 1'b0;
        end else begin
          key1_q <= (pwdata[7:0] == `PMWU_KEY_FIRST);
        end
      end else if (wr) begin
        key1_q <= 1'b0;
      end
      if (prot_hit && prot_ok)
        win_q <= 2'b00;
      if (state_q != state_d && (state_q == ST_IDLE || state_q == ST_STOP))
        power_control_q[1:0] <= 2'b00;
      if (wr_lo && hit(addr8, `PMWU_ADDR_POWER_CONTROL))
        power_control_q <= pwdata[7:0];
      if (wr_lo && hit(addr8, `PMWU_ADDR_EXT_FLAG)) begin
        ring_wake_select_q <= pwdata[`PMWU_BIT_RING_SEL];
        if (prot_ok)
          bgs_q <= pwdata[`PMWU_BIT_BANDGAP];
      end
      if (wr_lo && hit(addr8, `PMWU_ADDR_WATCHDOG_CTRL) && prot_ok) begin
        por_q <= pwdata[`PMWU_BIT_POR];
        ewt_q <= pwdata[`PMWU_BIT_WD_ENABLE];
        rwt_q <= pwdata[`PMWU_BIT_WD_RESTART];
        watchdog_irq_flag_q <= pwdata[`PMWU_BIT_WD_IRQ];
      end
      if (watchdog_irq_set)
        watchdog_irq_flag_q <= 1'b1;
    end
  end

  // read mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (hit(addr8, `PMWU_ADDR_POWER_CONTROL))
        prdata[7:0] <= power_control_q;
      else if (hit(addr8, `PMWU_ADDR_EXT_FLAG))
        prdata[2:0] <= {(state_q == ST_RING), ring_wake_select_q, bgs_q};
      else if (hit(addr8, `PMWU_ADDR_WATCHDOG_CTRL))
        prdata[7:0] <= {1'b0, por_q, 2'b00, watchdog_irq_flag_q, 1'b0, ewt_q, rwt_q};
    end
  end
endmodule // pmwu_top
`default_nettype wire

// ==== tb/pmwu_chk.sv ====
// assertion checker for the power mode and write unlock block
`timescale 1ns/10ps
`default_nettype none
module pmwu_chk #(
  parameter integer XTAL_SWITCH_CLOCKS = 65536
) (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // wake sources and controls
  input wire logic irq_enabled,
  input wire logic ext_irq,
  input wire logic power_fail_interrupt,
  input wire logic power_fail_reset,
  input wire logic cpu_halt,
  input wire logic periph_clk_en,
  input wire logic xtal_osc_en,
  input wire logic ring_osc_en,
  input wire logic clk_sel_ring,
  input wire logic bandgap_en,
  input wire logic watchdog_enable_bit
);
  logic [31:0] ring_cnt_q;
  wire         wr_w = psel & penable & pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles spent on the ring clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ring_cnt_q <= 32'h0;
    else
      ring_cnt_q <= clk_sel_ring ? ring_cnt_q + 32'h1 : 32'h0;
  end
  sequence s_stop_quiet;
    !periph_clk_en && !ext_irq && !power_fail_interrupt && !power_fail_reset;
  endsequence
  property p_idle_enter; $rose(cpu_halt) |-> $past(wr_w, 2); endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("halt without write");
  property p_idle_exit; (cpu_halt && periph_clk_en && irq_enabled)[*3] |=> !cpu_halt; endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
  property p_stop_off; !periph_clk_en |-> cpu_halt && !xtal_osc_en && !ring_osc_en; endproperty
  a_stop_off: assert property (p_stop_off) else $error("clock on in stop");
  property p_run_on; periph_clk_en |-> xtal_osc_en && bandgap_en; endproperty
  a_run_on: assert property (p_run_on) else $error("source off in run");
  property p_stop_hold; s_stop_quiet[*3] |=> !periph_clk_en; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left unwoken");
  property p_ring_start; $rose(clk_sel_ring) |-> $past(!periph_clk_en) && ring_osc_en; endproperty
  a_ring_start: assert property (p_ring_start) else $error("ring start");
  property p_xtal_switch; ring_cnt_q <= XTAL_SWITCH_CLOCKS + 4; endproperty
  a_xtal_switch: assert property (p_xtal_switch) else $error("ring held too long");
  property p_wd_enable; $rose(watchdog_enable_bit) |-> $past(wr_w); endproperty
  a_wd_enable: assert property (p_wd_enable) else $error("enable without write");
endmodule // pmwu_chk
bind pmwu_top pmwu_chk #(.XTAL_SWITCH_CLOCKS(XTAL_SWITCH_CLOCKS)) i_pmwu_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .irq_enabled(irq_enabled), .ext_irq(ext_irq), .power_fail_interrupt(power_fail_interrupt),
  .power_fail_reset(power_fail_reset), .cpu_halt(cpu_halt), .periph_clk_en(periph_clk_en),
  .xtal_osc_en(xtal_osc_en), .ring_osc_en(ring_osc_en), .clk_sel_ring(clk_sel_ring),
  .bandgap_en(bandgap_en), .watchdog_enable_bit(watchdog_enable_bit));
`default_nettype wire

// ==== tb/tb_top.sv ====
// testbench for the power mode and write unlock block
`timescale 1ns/10ps
`default_nettype none
`include "pmwu_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [11:0] A_PC = {2'b00, `PMWU_ADDR_POWER_CONTROL, 2'b00};
  localparam logic [11:0] A_EX = {2'b00, `PMWU_ADDR_EXT_FLAG, 2'b00};
  localparam logic [11:0] A_KY = {2'b00, `PMWU_ADDR_UNLOCK_KEY, 2'b00};
  localparam logic [11:0] A_WD = {2'b00, `PMWU_ADDR_WATCHDOG_CTRL, 2'b00};
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] r; logic e;} pmwu_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        irq_enabled = 1'b0, ext_irq = 1'b0, power_fail_interrupt = 1'b0, err;
  logic        power_fail_reset = 1'b0, wd_irq_set = 1'b0;
  wire logic   wd_restart, wd_irq_flag;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0]  rd;
  int          n_mismatch = 0, num_checks = 0;
  wire logic   pready, pslverr, cpu_halt, periph_clk_en, xtal_osc_en, ring_osc_en;
  wire logic   clk_sel_ring, bandgap_en, watchdog_enable_bit;
  wire logic [31:0] prdata;
  pmwu_row_t   rows [7] = '{'{1'b0, A_PC, 8'h00, 8'h00, 1'b0}, '{1'b0, A_WD, 8'h00, 8'h40, 1'b0},
    '{1'b0, A_EX, 8'h00, 8'h00, 1'b0}, '{1'b1, A_EX, 8'h03, 8'h00, 1'b0},
    '{1'b0, A_EX, 8'h00, 8'h02, 1'b0}, '{1'b1, A_WD, 8'h03, 8'h00, 1'b0},
    '{1'b0, 12'h004, 8'h00, 8'h00, 1'b1}};
  pmwu_top #(.XTAL_SWITCH_CLOCKS(16)) i_pmwu_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq_enabled(irq_enabled),
    .ext_irq(ext_irq), .power_fail_interrupt(power_fail_interrupt),
    .power_fail_reset(power_fail_reset),
    .cpu_halt(cpu_halt), .periph_clk_en(periph_clk_en), .xtal_osc_en(xtal_osc_en),
    .ring_osc_en(ring_osc_en), .clk_sel_ring(clk_sel_ring), .bandgap_en(bandgap_en),
    .watchdog_enable_bit(watchdog_enable_bit), .watchdog_restart_bit(wd_restart),
    .watchdog_irq_set(wd_irq_set), .watchdog_irq_flag(wd_irq_flag));
  always #50 pclk = ~pclk;
  // one apb transfer, left open for a back-to-back follower
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
  endtask
  task automatic idle_bus(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({cpu_halt, periph_clk_en, xtal_osc_en, bandgap_en, watchdog_enable_bit}, 5'b01110)
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK(err, rows[i].e)
      if (!rows[i].w) `CHK(rd, rows[i].r)
    end
    $display("table test done");
    apb(1'b1, A_KY, `PMWU_KEY_FIRST);
    apb(1'b1, A_KY, 8'h12);
    apb(1'b1, A_WD, 8'h02);
    idle_bus(1);
    `CHK(watchdog_enable_bit, 1'b0)
    apb(1'b1, A_KY, `PMWU_KEY_FIRST);
    apb(1'b1, A_KY, `PMWU_KEY_SECOND);
    apb(1'b1, A_WD, 8'h02);
    apb(1'b1, A_KY, `PMWU_KEY_FIRST);
    apb(1'b1, A_KY, `PMWU_KEY_SECOND);
    apb(1'b1, A_EX, 8'h03);
    apb(1'b1, A_EX, 8'h02);
    apb(1'b0, A_EX, 8'h00);
    `CHK({watchdog_enable_bit, rd}, 9'h103)
    $display("unlock test done");
    apb(1'b1, A_PC, 8'h01);
    idle_bus(2);
    `CHK({cpu_halt, periph_clk_en}, 2'b11)
    irq_enabled <= 1'b1;
    idle_bus(5);
    `CHK(cpu_halt, 1'b0)
    apb(1'b1, A_PC, 8'h02);
    idle_bus(5);
    `CHK({cpu_halt, periph_clk_en, xtal_osc_en, bandgap_en}, 4'b1001)
    ext_irq <= 1'b1;
    idle_bus(5);
    `CHK({clk_sel_ring, ring_osc_en, periph_clk_en}, 3'b111)
    ext_irq <= 1'b0;
    irq_enabled <= 1'b0;
    apb(1'b0, A_EX, 8'h00);
    `CHK(rd, 8'h07)
    apb(1'b1, A_PC, 8'h02);
    idle_bus(3);
    `CHK({ring_osc_en, periph_clk_en}, 2'b00)
    power_fail_interrupt <= 1'b1;
    idle_bus(5);
    `CHK(periph_clk_en, 1'b1)
    power_fail_interrupt <= 1'b0;
    idle_bus(24);
    `CHK(clk_sel_ring, 1'b0)
    apb(1'b1, A_KY, `PMWU_KEY_FIRST);
    apb(1'b1, A_KY, `PMWU_KEY_SECOND);
    apb(1'b1, A_WD, 8'h03);
    @(negedge pclk);
    `CHK({wd_restart, watchdog_enable_bit}, 2'b11)
    wd_irq_set <= 1'b1;
    apb(1'b1, A_KY, `PMWU_KEY_FIRST);
    apb(1'b1, A_KY, `PMWU_KEY_SECOND);
    apb(1'b1, A_WD, 8'h00);
    wd_irq_set <= 1'b0;
    @(negedge pclk);
    `CHK({wd_irq_flag, watchdog_enable_bit, wd_restart}, 3'b100)
    @(posedge pclk);
    apb(1'b1, A_PC, 8'h02);
    idle_bus(3);
    power_fail_reset <= 1'b1;
    idle_bus(5);
    `CHK({periph_clk_en, clk_sel_ring}, 2'b11)
    power_fail_reset <= 1'b0;
    $display("power mode test done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
